// *** hdl/dprs_pkg.sv ***
// Package for the debug port read and select register bank.
package dprs_pkg;
    // Register offsets
    localparam logic [7:0]  OFS_BANK4     = 8'h04;
    localparam logic [7:0]  OFS_REPLAY    = 8'h08;
    localparam logic [7:0]  OFS_POSTED_READ_BUFFER    = 8'h0c;
    localparam logic [7:0]  OFS_SELECT    = 8'h80;
    // Banks seen at offset 0x4
    localparam logic [3:0]  BANK_LPID     = 4'h3;
    localparam logic [3:0]  BANK_EVENT    = 4'h4;
    // Field positions and values
    localparam int          INST_LSB      = 28;
    localparam int          BANKSEL_W     = 4;
    localparam logic [3:0]  PROT_VERSION  = 4'h1;
    localparam logic [31:0] SELECT_RESET  = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET    = 32'h0000_0000;
    localparam int          APB_ADDR_W    = 32;

    // Debugger-side register request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  offset;
        logic [31:0] wdata;
    } dprs_req_t;

    // Access port read completion
    typedef struct packed {
        logic        valid;
        logic        ok;
        logic [31:0] rdata;
    } dprs_apresp_t;

    typedef enum logic { APB_IDLE, APB_BUSY } dprs_apb_st_t;

    // Whole state of the block
    typedef struct packed {
        logic [31:0]  select;
        logic [31:0]  last_rd;
        logic         read_ok;
        logic [1:0]   evt_sync;
        logic [31:0]  rdata;
        logic         rvalid;
        logic [31:0]  paddr;
        dprs_apb_st_t apb_st;
    } dprs_state_t;
endpackage : dprs_pkg

// *** hdl/dprs_regs.sv ***
// Debug port read/select register bank with APB address generation.
`timescale 1ns/1ps
module dprs_regs
    import dprs_pkg::*;
(
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          reset,
    // Configuration and tie-offs
    input  wire logic          serial_wire_config,
    input  wire logic [3:0]    target_instance_number,
    // Cross trigger
    input  wire logic          external_event_input,
    // Debugger register access
    input  wire dprs_req_t     req,
    output logic [31:0]        rdata,
    output logic               rvalid,
    // Access port request and completion
    input  wire logic          access_port_request,
    input  wire logic [1:0]    ap_addr,
    input  wire dprs_apresp_t  ap_resp,
    // Outputs towards the system
    output logic [31:0]        paddr,
    output logic               read_ok_flag,
    output logic [3:0]         port_bank_select
);
    dprs_state_t s_q;
    dprs_state_t s_d;
    logic [31:0] addr_mask;
    logic        rd_req;    // Read strobe, used by the checks
    logic        wr_req;    // Write strobe, used by the checks
    logic        rd_buf_sw; // Buffer read in serial wire configuration

    ////////////////////////////////////////////////////////////////
    // Implemented address bits; upper bits ignore writes
    assign addr_mask = (APB_ADDR_W >= 32) ? 32'hffff_ffff
                     : ((32'h0000_0001 << APB_ADDR_W) - 32'h0000_0001);

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        // Event input inverted, then two-stage synchroniser
        s_d.evt_sync = {s_q.evt_sync[0], ~external_event_input};
        // Access port read completion updates replay data and status
        if (ap_resp.valid) begin
            s_d.last_rd = ap_resp.rdata;
            s_d.read_ok = ap_resp.ok;
        end
        // Start of APB transfer latches address; held otherwise
        if (access_port_request) begin
            s_d.paddr  = {s_q.select[31:4], ap_addr, 2'b00};
            s_d.paddr  = s_d.paddr & addr_mask;
            s_d.apb_st = APB_BUSY;
        end else if (ap_resp.valid) begin
            s_d.apb_st = APB_IDLE;
        end
        if (req.valid) begin
            s_d.rvalid = ~req.write;
            // Read data stands until the next read; writes leave it
            if (!req.write)
                s_d.rdata = DATA_RESET;
            case ({req.write, req.offset})
                // Offset 0x4 read decoded by bank; write is upper select
                {1'b0, OFS_BANK4}: begin
                    if (s_q.select[3:0] == BANK_EVENT)
                        s_d.rdata = {31'h0000_0000, s_q.evt_sync[1]};
                    else if (s_q.select[3:0] == BANK_LPID)
                        s_d.rdata = {(serial_wire_config ?
                                     target_instance_number : 4'h0),
                                     24'h00_0000, PROT_VERSION};
                end
                {1'b1, OFS_BANK4}: ; // Upper select unused
                {1'b0, OFS_REPLAY}: begin
                    // No new transfer is started by a replay read
                    if (serial_wire_config)
                        s_d.rdata = s_q.last_rd;
                end
                {1'b0, OFS_POSTED_READ_BUFFER}: begin
                    // Buffer keeps last result; reads never launch transfers
                    if (serial_wire_config) begin
                        s_d.rdata   = s_q.last_rd;
                        s_d.read_ok = 1'b1;
                    end
                end
                {1'b1, OFS_SELECT}: begin
                    s_d.select = (req.wdata & addr_mask) |
                                 {28'h000_0000, req.wdata[3:0]};
                end
                default: ; // Writes to read-only offsets ignored
            endcase
        end
        if (!serial_wire_config)
            s_d.read_ok = 1'b0; // Read-ok reserved in JTAG
    end

    ////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '{select: SELECT_RESET, last_rd: DATA_RESET,
                     read_ok: 1'b0, evt_sync: 2'b11, rdata: DATA_RESET,
                     rvalid: 1'b0, paddr: DATA_RESET, apb_st: APB_IDLE};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign rdata            = s_q.rdata;
    assign rvalid           = s_q.rvalid;
    assign paddr            = s_q.paddr;
    assign read_ok_flag     = s_q.read_ok;
    assign port_bank_select = s_q.select[3:0];

    ////////////////////////////////////////////////////////////////
    // Strobes shared by the checks below
    assign rd_req    = req.valid && !req.write;
    assign wr_req    = req.valid && req.write;
    assign rd_buf_sw = rd_req && serial_wire_config
                     && req.offset == OFS_POSTED_READ_BUFFER;

    ////////////////////////////////////////////////////////////////
    // Checks: APB address
    // Low address bits never carry a byte offset
    word_align_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        paddr[1:0] == 2'b00)
        else $error("paddr not word aligned");

    // Address stands between transfers
    addr_hold_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !access_port_request |=> $stable(paddr))
        else $error("paddr moved without transfer");

    // Word select comes with each request
    addr_low_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        access_port_request |=> paddr[3:2] == $past(ap_addr))
        else $error("paddr word bits not from request");

    // Bank address comes from the select register
    addr_high_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        access_port_request |=> paddr[31:4] == $past(s_q.select[31:4]))
        else $error("paddr high bits not from select");

    // A request opens a transfer
    apb_busy_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        access_port_request |=> s_q.apb_st == APB_BUSY)
        else $error("transfer not marked busy");

    // A completion closes it, unless a new one starts
    apb_idle_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !access_port_request && ap_resp.valid |=> s_q.apb_st == APB_IDLE)
        else $error("transfer not closed");

    // Unimplemented address bits stay clear
    addr_mask_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (paddr & ~addr_mask) == 32'h0000_0000)
        else $error("paddr beyond implemented width");

    ////////////////////////////////////////////////////////////////
    // Checks: select register
    // Bank field follows a select write
    select_write_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_req && req.offset == OFS_SELECT
        |=> port_bank_select == $past(req.wdata[3:0]))
        else $error("bank select not written");

    // Address field keeps only implemented bits
    select_addr_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_req && req.offset == OFS_SELECT
        |=> s_q.select[31:4] == $past(req.wdata[31:4] & addr_mask[31:4]))
        else $error("select address not written");

    // Nothing else moves the select register
    select_hold_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !(wr_req && req.offset == OFS_SELECT) |=> $stable(s_q.select))
        else $error("select changed without write");

    // Upper select writes vanish
    upper_select_unused_ign_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_req && req.offset == OFS_BANK4 |=> $stable(s_q.select))
        else $error("upper select write changed state");

    // Outputs at their reset values once reset drops
    reset_value_a: assert property (
        @(posedge ref_clk)
        $fell(reset) |-> paddr == 32'h0000_0000 && !rvalid && !read_ok_flag
        && port_bank_select == 4'h0 && s_q.evt_sync == 2'b11)
        else $error("outputs not at reset values");

    ////////////////////////////////////////////////////////////////
    // Checks: read answers
    // Every read is answered one cycle on
    rvalid_read_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_req |=> rvalid)
        else $error("read not answered");

    // Writes and idle cycles give no answer
    rvalid_none_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !rd_req |=> !rvalid)
        else $error("answer without read");

    // Read data stands until the next read
    rdata_hold_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !rd_req |=> $stable(rdata))
        else $error("read data moved without read");

    // Two-stage path from the event pin, inverted
    event_sync_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        ##2 s_q.evt_sync[1] == !$past(external_event_input, 2))
        else $error("event status not inverted sync");

    // Event bank shows the synchronised flag alone
    event_read_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_req && req.offset == OFS_BANK4 && s_q.select[3:0] == BANK_EVENT
        |=> rdata == {31'h0000_0000, $past(s_q.evt_sync[1])})
        else $error("event status read wrong");

    // Instance field from the tie-off in serial wire
    inst_serial_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_req && serial_wire_config && req.offset == OFS_BANK4
        && s_q.select[3:0] == BANK_LPID
        |=> rdata[31:28] == $past(target_instance_number))
        else $error("instance field not from tie-off");

    // Instance field hidden in JTAG
    inst_jtag_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_req && !serial_wire_config && req.offset == OFS_BANK4
        && s_q.select[3:0] == BANK_LPID |=> rdata[31:28] == 4'h0)
        else $error("instance field visible in jtag");

    // Protocol version fixed in both configurations
    version_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_req && req.offset == OFS_BANK4 && s_q.select[3:0] == BANK_LPID
        |=> rdata[3:0] == PROT_VERSION && rdata[27:4] == 24'h00_0000)
        else $error("protocol version wrong");

    // Banks without a register here read zero
    other_bank_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_req && req.offset == OFS_BANK4 && s_q.select[3:0] != BANK_LPID
        && s_q.select[3:0] != BANK_EVENT |=> rdata == 32'h0000_0000)
        else $error("empty bank not zero");

    // Unknown and write-only offsets read zero
    unknown_ofs_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_req && req.offset != OFS_BANK4 && req.offset != OFS_REPLAY
        && req.offset != OFS_POSTED_READ_BUFFER |=> rdata == 32'h0000_0000)
        else $error("unknown offset not zero");

    ////////////////////////////////////////////////////////////////
    // Checks: replay, buffer and status
    // Replay reads zero in JTAG
    jtag_zero_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_req && !serial_wire_config && req.offset == OFS_REPLAY
        |=> rvalid && rdata == 32'h0000_0000)
        else $error("jtag replay not zero");

    // Buffer reads zero in JTAG
    posted_read_buffer_jtag_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_req && !serial_wire_config && req.offset == OFS_POSTED_READ_BUFFER
        |=> rvalid && rdata == 32'h0000_0000)
        else $error("jtag buffer not zero");

    // Replay returns the last result
    replay_data_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_req && serial_wire_config && req.offset == OFS_REPLAY
        |=> rdata == $past(s_q.last_rd))
        else $error("replay data mismatch");

    // Buffer returns the last result
    buffer_data_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_buf_sw |=> rdata == $past(s_q.last_rd))
        else $error("buffer data mismatch");

    // A second buffer read repeats the first
    buffer_repeat_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_buf_sw && !ap_resp.valid ##1 rd_buf_sw
        |=> rdata == $past(rdata))
        else $error("repeated buffer read differs");

    // Only a completion refreshes the result; reads start nothing
    last_keep_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !ap_resp.valid |=> $stable(s_q.last_rd))
        else $error("result moved without completion");

    // A completion is captured whole
    last_load_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        ap_resp.valid |=> s_q.last_rd == $past(ap_resp.rdata))
        else $error("completion data not captured");

    // Read-ok follows the completion response
    read_ok_resp_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        ap_resp.valid && serial_wire_config && !rd_buf_sw
        |=> read_ok_flag == $past(ap_resp.ok))
        else $error("read-ok not from response");

    // A buffer read is answered OK and wins a collision
    read_ok_buf_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_buf_sw |=> read_ok_flag)
        else $error("read-ok not set by buffer read");

    // Read-ok is reserved in JTAG
    read_ok_jtag_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !serial_wire_config |=> !read_ok_flag)
        else $error("read-ok set in jtag");
endmodule : dprs_regs

// *** tb/dprs_ap_model.sv ***
// Access port model that answers reads for the register bank.
`timescale 1ns/1ps
module dprs_ap_model
    import dprs_pkg::*;
#(
    parameter logic [31:0] MIX = 32'h5a5a_5a5a
)
(
    // Clock, reset and request
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        access_port_request,
    input  wire logic [31:0] paddr,
    input  wire logic        ok_in,
    // Completion
    output dprs_apresp_t     ap_resp
);
    logic [1:0] wait_q;
    // Answers three cycles on; idle data toggles so stale values never match
    always_ff @(posedge ref_clk) begin
        wait_q <= reset ? 2'b00 : {wait_q[0], access_port_request};
        ap_resp.valid <= !reset && wait_q[1];
        ap_resp.ok <= ok_in;
        ap_resp.rdata <= wait_q[1] ? (paddr ^ MIX) : ~ap_resp.rdata;
    end
endmodule : dprs_ap_model

// *** tb/test_dprs_regs.sv ***
// Self-checking bench for the debug port read/select register bank.
`timescale 1ns/1ps
module test_dprs_regs;
    import dprs_pkg::*;
    localparam logic [31:0] MIX = 32'h5a5a_5a5a;
    localparam logic [3:0]  INST = 4'h9;
    logic ref_clk, reset, serial_wire_config, external_event_input;
    logic access_port_request, rvalid, read_ok_flag, ok_in;
    logic [3:0]  target_instance_number, port_bank_select;
    logic [1:0]  ap_addr;
    logic [31:0] rdata, paddr;
    dprs_req_t    req;
    dprs_apresp_t ap_resp;
    int errors, compares;
    dprs_regs dprs_regs_inst (.ref_clk, .reset, .serial_wire_config,
        .target_instance_number, .external_event_input, .req, .rdata,
        .rvalid, .access_port_request, .ap_addr, .ap_resp, .paddr,
        .read_ok_flag, .port_bank_select);
    dprs_ap_model #(.MIX(MIX)) dprs_ap_model_inst (.ref_clk, .reset,
        .access_port_request, .paddr, .ok_in, .ap_resp);
    ////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        req = '{1'b1, 1'b1, ofs, d};
        @(negedge ref_clk) req = '0;
        @(negedge ref_clk);
    endtask : wr
    // Answer pulse and data checked one cycle on, then the pulse must be gone
    task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
        req = '{1'b1, 1'b0, ofs, 32'h0000_0000};
        @(negedge ref_clk) req = '0;
        chk({31'h0, rvalid}, 32'h0000_0001);
        chk(rdata, exp);
        @(negedge ref_clk);
        chk({31'h0, rvalid}, 32'h0000_0000);
    endtask : rdc
    task automatic ap(input logic [1:0] a, input logic [31:0] exp);
        access_port_request = 1'b1;
        ap_addr = a;
        @(negedge ref_clk) access_port_request = 1'b0;
        chk(paddr, exp);
        for (int i = 0; i < 6 && ap_resp.valid !== 1'b1; i++)
            @(negedge ref_clk);
        @(negedge ref_clk);
    endtask : ap
    task automatic do_reset;
        reset = 1'b1;
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_ident;
        rdc(OFS_POSTED_READ_BUFFER, DATA_RESET);
        rdc(OFS_REPLAY, DATA_RESET);
        chk({28'h0, port_bank_select}, 32'h0000_0000);
        wr(OFS_SELECT, {28'h0, BANK_LPID});
        chk({28'h0, port_bank_select}, {28'h0, BANK_LPID});
        rdc(OFS_BANK4, {INST, 24'h0, PROT_VERSION});
    endtask : t_ident
    task automatic t_event;
        wr(OFS_SELECT, {28'h0, BANK_EVENT});
        external_event_input = 1'b1;
        repeat (3) @(negedge ref_clk);
        rdc(OFS_BANK4, 32'h0000_0000);
        external_event_input = 1'b0;
        repeat (3) @(negedge ref_clk);
        rdc(OFS_BANK4, 32'h0000_0001);
        wr(OFS_SELECT, 32'h0000_0000);
        rdc(OFS_BANK4, 32'h0000_0000);
        rdc(OFS_SELECT, 32'h0000_0000);
    endtask : t_event
    // Posted reads, replay, and an ignored upper select write
    task automatic t_apb;
        wr(OFS_SELECT, 32'h1234_5674);
        ap(2'b10, 32'h1234_5678);
        wr(OFS_BANK4, 32'hffff_ffff);
        chk(paddr, 32'h1234_5678);
        rdc(OFS_POSTED_READ_BUFFER, 32'h1234_5678 ^ MIX);
        wr(OFS_POSTED_READ_BUFFER, 32'h0000_0000);
        chk(rdata, 32'h1234_5678 ^ MIX);
        rdc(OFS_POSTED_READ_BUFFER, 32'h1234_5678 ^ MIX);
        rdc(OFS_REPLAY, 32'h1234_5678 ^ MIX);
        chk({31'h0, read_ok_flag}, 32'h0000_0001);
        ok_in = 1'b0;
        ap(2'b01, 32'h1234_5674);
        chk({31'h0, read_ok_flag}, 32'h0000_0000);
        rdc(OFS_REPLAY, 32'h1234_5674 ^ MIX);
        rdc(OFS_POSTED_READ_BUFFER, 32'h1234_5674 ^ MIX);
        chk({31'h0, read_ok_flag}, 32'h0000_0001);
    endtask : t_apb
    // JTAG strap: buffer and replay read zero, instance field hidden
    task automatic t_jtag;
        serial_wire_config = 1'b0;
        do_reset();
        wr(OFS_POSTED_READ_BUFFER, 32'hffff_ffff);
        rdc(OFS_POSTED_READ_BUFFER, 32'h0000_0000);
        rdc(OFS_REPLAY, 32'h0000_0000);
        wr(OFS_SELECT, {28'h0, BANK_LPID});
        rdc(OFS_BANK4, {28'h0, PROT_VERSION});
    endtask : t_jtag
    ////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    // Clock at 40 MHz
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Watchdog at 4000 cycles, well beyond the under 100 cycles the run needs
    initial begin
        #100_000;
        errors++;
        conclude();
    end
    initial begin
        {req, access_port_request, ap_addr, external_event_input} = '0;
        serial_wire_config = 1'b1;
        ok_in = 1'b1;
        target_instance_number = INST;
        do_reset();
        t_ident();
        t_event();
        t_apb();
        t_jtag();
        conclude();
    end
endmodule : test_dprs_regs
